//--- logic/cgr_defines.vh
// constants for the core general register file and byte-order state
`ifndef CGR_DEFINES_VH
`define CGR_DEFINES_VH
`define CGR_WIDTH 32
`define CGR_NREGS 32
`define CGR_IDX_W 5
`define CGR_SETS 2
`define CGR_SET_W 1
`define CGR_NFLAGS 8
`define CGR_BE_LITTLE 1'b0
`define CGR_BE_BIG 1'b1
// apb map
`define CGR_ADDR_W 12
`define CGR_A_CTRL 12'h000
`define CGR_A_STAT 12'h004
`define CGR_A_RIDX 12'h008
`define CGR_A_RDAT 12'h00c
`define CGR_A_FIELD 12'h010
`define CGR_A_FRES 12'h014
// control register fields
`define CGR_C_CSS 0
`define CGR_C_REV 4
`define CGR_C_UM 5
`define CGR_C_KERN 6
`define CGR_C_CP0 7
`define CGR_C_DBG 8
// index register and field register positions
`define CGR_R_SET 8
`define CGR_F_HI_H 12
`define CGR_F_HI_L 8
`define CGR_F_LO_H 4
// strap settles through two flops before capture
`define CGR_STRAP_WAIT 2'h2
// mode field values
`define CGR_MODE_W 2
`define CGR_MODE_KERN 2'h0
`define CGR_MODE_USER 2'h1
`define CGR_MODE_DBG 2'h2
`endif

//--- logic/cgr_core_regs.v
// general register file, shadow sets and byte-order state
`timescale 1ns/1ns
`default_nettype none
`include "cgr_defines.vh"
module cgr_core_regs (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // byte-order strap
  input wire order_strap,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`CGR_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // core register ports
  input wire [`CGR_IDX_W-1:0] rd_a_idx,
  input wire [`CGR_IDX_W-1:0] rd_b_idx,
  output reg [`CGR_WIDTH-1:0] rd_a_data,
  output reg [`CGR_WIDTH-1:0] rd_b_data,
  input wire wr_en,
  input wire [`CGR_IDX_W-1:0] wr_idx,
  input wire [`CGR_WIDTH-1:0] wr_data,
  // shadow set access from privileged code
  input wire shadow_wr_en,
  input wire [`CGR_SET_W-1:0] shadow_set,
  // condition signal from coprocessor unit 1
  input wire coprocessor_condition_signal,
  // byte-order and condition outputs
  output reg memory_byte_order,
  output reg load_store_byte_order,
  output reg user_order_flip,
  output reg fp_condition_flag,
  output reg undef_allowed
);

  // bit-field select, rightmost bit zero, empty when hi below lo
  function [31:0] field_sel;
    input [31:0] val;
    input [4:0] hi;
    input [4:0] lo;
    reg [31:0] msk;
    begin
      msk = (32'hffffffff >> (5'd31 - hi)) & (32'hffffffff << lo);
      if (hi < lo) begin
        field_sel = 32'h0;
      end else begin
        field_sel = (val & msk) >> lo;
      end
    end
  endfunction

  // shadow-set read with register zero forced
  function [`CGR_WIDTH-1:0] zero_guard;
    input [`CGR_IDX_W-1:0] idx;
    input [`CGR_WIDTH-1:0] val;
    begin
      zero_guard = (idx == {`CGR_IDX_W{1'b0}}) ? {`CGR_WIDTH{1'b0}} : val;
    end
  endfunction

  reg [`CGR_WIDTH-1:0] general_register [0:`CGR_SETS*`CGR_NREGS-1];
  reg [`CGR_SET_W-1:0] current_shadow_set_q;
  reg reverse_order_bit_q;
  reg [`CGR_MODE_W-1:0] mode_q;
  reg cp0_usable_q;
  reg order_q;
  reg strap_s1_q;
  reg strap_s2_q;
  reg strap_taken_q;
  reg [`CGR_SET_W-1:0] dbg_set_q;
  reg [`CGR_IDX_W-1:0] dbg_idx_q;
  reg [31:0] field_q;
  reg [`CGR_WIDTH-1:0] dbg_rd;
  reg [1:0] strap_cnt_q;
  reg [`CGR_SET_W-1:0] current_shadow_set_d;
  reg reverse_order_bit_d;
  reg cp0_usable_d;
  reg [`CGR_MODE_W-1:0] mode_d;
  reg [`CGR_SET_W-1:0] dbg_set_d;
  reg [`CGR_IDX_W-1:0] dbg_idx_d;
  reg [31:0] field_d;
  reg [31:0] rd_word_d;
  wire user_mode;
  wire priv;
  wire apb_wr;
  wire apb_setup;
  wire [`CGR_SET_W-1:0] wr_set;
  integer i;

  assign user_mode = (mode_q == `CGR_MODE_USER);
  assign priv = !user_mode || cp0_usable_q;
  assign apb_wr = psel && penable && pwrite;
  assign apb_setup = psel && !penable;
  // user code without cp0 usable may only reach its own set; shadow writes need privilege
  assign wr_set = (shadow_wr_en && priv) ? shadow_set : current_shadow_set_q;

  // strap synchroniser, captured once after reset release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
      strap_taken_q <= 1'b0;
      strap_cnt_q <= 2'h0;
      order_q <= `CGR_BE_LITTLE;
    end else begin
      strap_s1_q <= order_strap;
      strap_s2_q <= strap_s1_q;
      // wait until stage two holds the pin, not its reset value
      if (strap_cnt_q != `CGR_STRAP_WAIT) begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end else if (!strap_taken_q) begin
        strap_taken_q <= 1'b1;
        order_q <= strap_s2_q;
      end
    end
  end

  // register array write; index zero never stored
  always @(posedge pclk) begin
    if (wr_en && (wr_idx != {`CGR_IDX_W{1'b0}})) begin
      general_register[{wr_set, wr_idx}] <= wr_data;
    end
  end

  // apb readback of a register in the selected set
  always @* begin
    dbg_rd = zero_guard(dbg_idx_q, general_register[{dbg_set_q, dbg_idx_q}]);
  end

  // write refused: read-only or unmapped offsets
  function wr_refused;
    input [`CGR_ADDR_W-1:0] addr;
    begin
      if (addr == `CGR_A_CTRL) begin
        wr_refused = 1'b0;
      end else if (addr == `CGR_A_RIDX) begin
        wr_refused = 1'b0;
      end else if (addr == `CGR_A_FIELD) begin
        wr_refused = 1'b0;
      end else begin
        wr_refused = 1'b1;
      end
    end
  endfunction

  // read refused: unmapped offsets only
  function rd_refused;
    input [`CGR_ADDR_W-1:0] addr;
    begin
      if (addr == `CGR_A_CTRL || addr == `CGR_A_STAT || addr == `CGR_A_RIDX) begin
        rd_refused = 1'b0;
      end else if (addr == `CGR_A_RDAT || addr == `CGR_A_FIELD || addr == `CGR_A_FRES) begin
        rd_refused = 1'b0;
      end else begin
        rd_refused = 1'b1;
      end
    end
  endfunction

  // control word to mode, debug taking precedence over user
  function [`CGR_MODE_W-1:0] mode_decode;
    input [31:0] ctrl;
    begin
      if (ctrl[`CGR_C_DBG]) begin
        mode_decode = `CGR_MODE_DBG;
      end else if (ctrl[`CGR_C_UM]) begin
        mode_decode = `CGR_MODE_USER;
      end else begin
        mode_decode = `CGR_MODE_KERN;
      end
    end
  endfunction

  // next control state from an accepted write
  always @* begin
    current_shadow_set_d = current_shadow_set_q;
    reverse_order_bit_d = reverse_order_bit_q;
    cp0_usable_d = cp0_usable_q;
    mode_d = mode_q;
    dbg_set_d = dbg_set_q;
    dbg_idx_d = dbg_idx_q;
    field_d = field_q;
    if (apb_wr && pready) begin
      if (paddr == `CGR_A_CTRL) begin
        current_shadow_set_d = pwdata[`CGR_C_CSS+`CGR_SET_W-1:`CGR_C_CSS];
        reverse_order_bit_d = pwdata[`CGR_C_REV];
        cp0_usable_d = pwdata[`CGR_C_CP0];
        mode_d = mode_decode(pwdata);
      end else if (paddr == `CGR_A_RIDX) begin
        // user mode without cp0 usable may only inspect its current set
        dbg_set_d = priv ? pwdata[`CGR_R_SET+`CGR_SET_W-1:`CGR_R_SET]
                         : current_shadow_set_q;
        dbg_idx_d = pwdata[`CGR_IDX_W-1:0];
      end else if (paddr == `CGR_A_FIELD) begin
        field_d = pwdata;
      end
    end
  end

  // read word for the addressed register
  always @* begin
    rd_word_d = 32'h0;
    if (paddr == `CGR_A_CTRL) begin
      rd_word_d = {23'h0, mode_q == `CGR_MODE_DBG, cp0_usable_q,
                   mode_q == `CGR_MODE_KERN, user_mode, reverse_order_bit_q,
                   {(4-`CGR_SET_W){1'b0}}, current_shadow_set_q};
    end else if (paddr == `CGR_A_STAT) begin
      rd_word_d = {27'h0, undef_allowed, fp_condition_flag, user_order_flip,
                   load_store_byte_order, memory_byte_order};
    end else if (paddr == `CGR_A_RIDX) begin
      rd_word_d = {23'h0, dbg_set_q, 3'h0, dbg_idx_q};
    end else if (paddr == `CGR_A_RDAT) begin
      rd_word_d = dbg_rd;
    end else if (paddr == `CGR_A_FIELD) begin
      rd_word_d = field_q;
    end else if (paddr == `CGR_A_FRES) begin
      rd_word_d = field_sel(field_q, field_q[`CGR_F_HI_H:`CGR_F_HI_L],
                            field_q[`CGR_F_LO_H:0]);
    end else begin
      rd_word_d = 32'h0;
    end
  end

  // control state and apb slave
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_shadow_set_q <= {`CGR_SET_W{1'b0}};
      reverse_order_bit_q <= 1'b0;
      mode_q <= `CGR_MODE_KERN;
      cp0_usable_q <= 1'b0;
      dbg_set_q <= {`CGR_SET_W{1'b0}};
      dbg_idx_q <= {`CGR_IDX_W{1'b0}};
      field_q <= 32'h0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      current_shadow_set_q <= current_shadow_set_d;
      reverse_order_bit_q <= reverse_order_bit_d;
      cp0_usable_q <= cp0_usable_d;
      mode_q <= mode_d;
      dbg_set_q <= dbg_set_d;
      dbg_idx_q <= dbg_idx_d;
      field_q <= field_d;
      pready <= apb_setup; // no wait states, never stalls
      if (apb_setup) begin
        // error flag must stand beside ready in the access cycle
        pslverr <= pwrite ? wr_refused(paddr) : rd_refused(paddr);
        if (!pwrite) begin
          prdata <= rd_word_d;
        end
      end
    end
  end

  // byte-order, condition and read port outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      memory_byte_order <= `CGR_BE_LITTLE;
      load_store_byte_order <= `CGR_BE_LITTLE;
      user_order_flip <= 1'b0;
      fp_condition_flag <= 1'b0;
      undef_allowed <= 1'b0;
      rd_a_data <= {`CGR_WIDTH{1'b0}};
      rd_b_data <= {`CGR_WIDTH{1'b0}};
    end else begin
      memory_byte_order <= order_q;
      user_order_flip <= reverse_order_bit_q && user_mode;
      load_store_byte_order <= order_q ^ (reverse_order_bit_q && user_mode);
      fp_condition_flag <= coprocessor_condition_signal;
      undef_allowed <= priv;
      rd_a_data <= zero_guard(rd_a_idx,
                              general_register[{current_shadow_set_q, rd_a_idx}]);
      rd_b_data <= zero_guard(rd_b_idx,
                              general_register[{current_shadow_set_q, rd_b_idx}]);
    end
  end

  // array starts cleared so no stale data leaks between processes
  initial begin
    for (i = 0; i < `CGR_SETS*`CGR_NREGS; i = i + 1) begin
      general_register[i] = {`CGR_WIDTH{1'b0}};
    end
  end

endmodule // cgr_core_regs
`default_nettype wire

//--- testbench/cgr_asserts.sv
// port assertions for the core register file
`timescale 1ns/1ns
`default_nettype none
`include "cgr_defines.vh"
module cgr_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // core ports
  input wire logic [`CGR_IDX_W-1:0] rd_a_idx,
  input wire logic [`CGR_IDX_W-1:0] rd_b_idx,
  input wire logic [`CGR_WIDTH-1:0] rd_a_data,
  input wire logic [`CGR_WIDTH-1:0] rd_b_data,
  input wire logic wr_en,
  input wire logic [`CGR_IDX_W-1:0] wr_idx,
  input wire logic [`CGR_WIDTH-1:0] wr_data,
  input wire logic shadow_wr_en,
  // order and condition state
  input wire logic coprocessor_condition_signal,
  input wire logic memory_byte_order,
  input wire logic load_store_byte_order,
  input wire logic user_order_flip,
  input wire logic fp_condition_flag
);
  // one clock domain for every check
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_zero_a: assert property (rd_a_idx == 5'h00 |=> rd_a_data == 32'h0)
    else $error("port a reg zero not zero");
  a_zero_b: assert property (rd_b_idx == 5'h00 |=> rd_b_data == 32'h0)
    else $error("port b reg zero not zero");
  a_write_seen: assert property (wr_en && !shadow_wr_en && wr_idx != 5'h00 ##1
    rd_a_idx == $past(wr_idx) |=> rd_a_data == $past(wr_data, 2))
    else $error("written value not read back");
  a_order_xor: assert property (
    load_store_byte_order == (memory_byte_order ^ user_order_flip))
    else $error("load store order wrong");
  a_fp_copy: assert property (fp_condition_flag == $past(coprocessor_condition_signal))
    else $error("fp flag not following condition");
  a_order_fixed: assert property ($past(presetn, 5) |-> $stable(memory_byte_order))
    else $error("memory order changed");
  a_no_hang: assert property (psel && !penable |-> ##[1:4] pready)
    else $error("apb request not answered");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
endmodule // cgr_asserts
bind cgr_core_regs cgr_asserts i_chk (.pclk, .presetn, .psel, .penable, .pready, .rd_a_idx,
  .rd_b_idx, .rd_a_data, .rd_b_data, .wr_en, .wr_idx, .wr_data, .shadow_wr_en,
  .coprocessor_condition_signal, .memory_byte_order, .load_store_byte_order,
  .user_order_flip, .fp_condition_flag);
`default_nettype wire

//--- testbench/cgr_core_regs_test.sv
// self-checking bench for the core register file
`timescale 1ns/1ns
`default_nettype none
`include "cgr_defines.vh"
module cgr_core_regs_test;
  // stimulus, answers and notes
  reg pclk = 0, presetn = 0, psel = 0, pen = 0, pwr = 0, we = 0, cc = 0, rv = 0, rv1 = 0;
  reg current_shadow_set = 0, strap = 0;
  reg [11:0] pa = 0;
  reg [4:0] ra = 0, wi = 0;
  reg [31:0] pwd = 0, wd = 0, m [0:63];
  wire [31:0] prd, rda;
  wire prdy, perr;
  reg [32:0] qa [$];
  reg [31:0] qr [$];
  integer failures = 0, num_checks = 0, seed = 9905, i, s;
  cgr_core_regs i_dut (.pclk(pclk), .presetn(presetn), .order_strap(strap), .psel(psel),
    .penable(pen), .pwrite(pwr), .paddr(pa), .pwdata(pwd), .prdata(prd), .pready(prdy),
    .pslverr(perr), .rd_a_idx(ra), .rd_b_idx(wi), .rd_a_data(rda), .rd_b_data(),
    .wr_en(we), .wr_idx(wi), .wr_data(wd), .shadow_wr_en(1'b0), .shadow_set(1'b0),
    .coprocessor_condition_signal(cc), .memory_byte_order(), .load_store_byte_order(),
    .user_order_flip(), .fp_condition_flag(), .undef_allowed());
  initial forever #20 pclk = ~pclk;
  task cmp(input [15:0] k, input [32:0] g, input [32:0] e);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("BAD %0t %s got %h want %h", $time, k, g, e);
      end
    end
  endtask
  task chk_apb(input [32:0] g, input [32:0] e); cmp("ap", g, e); endtask
  task chk_rd(input [31:0] g, input [31:0] e); cmp("rd", {1'b0, g}, {1'b0, e}); endtask
  task report_and_stop;
    begin
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // one apb transfer, held until ready
  task apb(input w, input [11:0] a, input [31:0] d, input [32:0] e);
    begin
      qa.push_back(e);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge pclk) pen <= 1'b1;
      @(posedge pclk) while (prdy !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge pclk);
    end
  endtask
  // core write and read in one cycle
  task op(input [4:0] x, input [31:0] v, input [4:0] r);
    begin
      qr.push_back(r == 5'h00 ? 32'h0 : m[{current_shadow_set, r}]);
      if (x != 5'h00) m[{current_shadow_set, x}] = v;
      we <= 1'b1;
      wi <= x;
      wd <= v;
      ra <= r;
      rv <= 1'b1;
      cc <= $random(seed);
      @(posedge pclk);
    end
  endtask
  task idle;
    begin
      we <= 1'b0;
      rv <= 1'b0;
      cc <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task mode(input [31:0] c, input [31:0] e);
    begin
      apb(1'b1, `CGR_A_CTRL, c, 33'h0);
      apb(1'b0, `CGR_A_STAT, 32'h0, {1'b0, e});
    end
  endtask
  // answers compared with the oldest note
  always @(posedge pclk) begin
    rv1 <= rv;
    if (prdy === 1'b1) chk_apb({perr, pwr ? 32'h0 : prd}, qa.pop_front());
    if (rv1) chk_rd(rda, qr.pop_front());
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, `CGR_A_STAT, 32'h0, 33'h10);
    for (i = 0; i < 64; i = i + 1) begin
      if (i[4:0] == 5'h00) begin
        idle;
        current_shadow_set = i[5];
        apb(1'b1, `CGR_A_CTRL, {31'h0, current_shadow_set}, 33'h0);
      end
      else op(i[4:0], $random(seed), i[4:0] - 5'h01);
    end
    for (i = 0; i < 60; i = i + 1) begin
      s = $random(seed);
      op(s[4:0], $random(seed), s[4:0] + 5'h01);
    end
    idle;
    current_shadow_set = 1'b0;
    apb(1'b1, `CGR_A_CTRL, 32'h0, 33'h0);
    for (i = 0; i < 32; i = i + 1) op(5'h00, $random(seed), i[4:0]);
    idle;
    mode(32'h10, 32'h10);
    mode(32'h30, 32'h06);
    mode(32'h130, 32'h10);
    mode(32'ha0, 32'h10);
    mode(32'h20, 32'h0);
    apb(1'b1, `CGR_A_RIDX, 32'h103, 33'h0);
    apb(1'b0, `CGR_A_RDAT, 32'h0, {1'b0, m[3]});
    apb(1'b1, `CGR_A_CTRL, 32'h0, 33'h0);
    apb(1'b1, `CGR_A_RIDX, 32'h103, 33'h0);
    apb(1'b0, `CGR_A_RDAT, 32'h0, {1'b0, m[35]});
    apb(1'b1, `CGR_A_FIELD, 32'hdead0b04, 33'h0);
    apb(1'b0, `CGR_A_FRES, 32'h0, 33'hb0);
    apb(1'b1, `CGR_A_FIELD, 32'h305, 33'h0);
    apb(1'b0, `CGR_A_FRES, 32'h0, 33'h0);
    apb(1'b1, `CGR_A_STAT, 32'h1, 33'h100000000);
    apb(1'b0, 12'h018, 32'h0, 33'h100000000);
    presetn <= 1'b0;
    strap <= 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, `CGR_A_STAT, 32'h0, 33'h13);
    report_and_stop;
  end
  // cut a hang short
  initial begin
    #200000;
    failures = failures + 1;
    report_and_stop;
  end
endmodule // cgr_core_regs_test
`default_nettype wire
